//--- flash_status_consts.svh
/*
 Constants of the flash status and identity register bank: offsets, field
 positions, reset values and identity defaults.
 Assumes inclusion by bare name from the register bank module flash_status_regs.
*/
`ifndef FLASH_STATUS_CONSTS_SVH
`define FLASH_STATUS_CONSTS_SVH

// ==========================================================
// Register offsets (byte addresses)
`define OFS_IRQ_ENABLE      12'h014
`define OFS_IRQ_STATUS      12'h018
`define OFS_PAGE_PROT_0     12'h020
`define OFS_PAGE_PROT_1     12'h024
`define OFS_PAGE_PROT_2     12'h028
`define OFS_PAGE_PROT_3     12'h02c
`define OFS_SECURITY        12'h030
`define OFS_VECTOR_MAP      12'h100
`define OFS_MAKER_PART      12'h180
`define OFS_PAGE_COUNT      12'h184
`define OFS_PAGE_SIZE       12'h188
`define OFS_PART_ID         12'h18c
`define OFS_CUSTOM_0        12'h310
`define OFS_CUSTOM_1        12'h314
`define OFS_CUSTOM_2        12'h318
`define OFS_CUSTOM_3        12'h31c

// ==========================================================
// Field positions
`define BIT_DONE            0
`define BIT_BAD_ADDR        1
`define BIT_CHECKSUM        2
`define BIT_VECTOR_SEL      1
`define FLAG_WIDTH          3

// ==========================================================
// Values
`define ADDR_LIMIT          32'h1fff_ffff
`define PAGE_SIZE_RESET     32'h0000_0400
`define PAGE_COUNT_DEFAULT  32'h0000_0080
`define MAKER_CODE_DEFAULT  16'h5a5a
`define PART_LAST4_DEFAULT  16'h1234
`define PART_FULL_DEFAULT   20'h12345
`define ZERO_WORD           32'h0000_0000

`endif

//--- flash_status_pkg.sv
/*
 Types shared by the flash status and identity register bank.
 Assumes flash_status_consts.svh is on the include path.
*/
package flash_status_pkg;

   // ==========================================================
   // Classic Wishbone request and answer
   typedef struct packed {
      logic        cyc;
      logic        stb;
      logic        we;
      logic [3:0]  sel;
      logic [11:0] adr;
      logic [31:0] dat;
   } wb_req_type;

   typedef struct packed {
      logic        ack;
      logic [31:0] dat;
   } wb_rsp_type;

   // Operation events from the command sequencer
   typedef struct packed {
      logic        op_done;
      logic        addr_check;
      logic [31:0] target_address_value;
      logic        checksum_bad;
   } op_event_type;

   // Bus slave state
   typedef enum logic [0:0] {
      BUS_IDLE,
      BUS_ACK
   } bus_state_type;

endpackage

//--- flash_page_guard.sv
/*
 Page guard: decides whether an erase or program request on a page is
 allowed from the latched protection image.
 Assumes page index and image are on clk_i; one or two pages per bit.
*/
module flash_page_guard
(
   // Clock and control
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   input  wire logic         ce_i,
   // Request
   input  wire logic         two_pages_i,
   input  wire logic [7:0]   page_i,
   input  wire logic         req_i,
   input  wire logic [127:0] protect_i,
   // Answer
   output logic              allow_o,
   output logic              refuse_o
);

   // ==========================================================
   // Page to status bit; with two pages per bit the index halves
   wire logic [7:0] bit_index;
   wire logic       page_open;

   assign bit_index = two_pages_i ? {1'b0, page_i[7:1]} : page_i;
   assign page_open = ~bit_index[7] & protect_i[bit_index[6:0]];

   // Zero bit means protected: refuse the operation
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         allow_o  <= 1'b0;
         refuse_o <= 1'b0;
      end
      else if (ce_i)
      begin
         allow_o  <= req_i & page_open;
         refuse_o <= req_i & ~page_open;
      end
   end

endmodule

//--- flash_status_regs.sv
/*
 Flash status, protection status, vector mapping and identity register
 bank with a classic Wishbone slave and one level interrupt.
 Assumes option bytes, boot pin and privilege words are stable around
 reset; event inputs come from logic on clk_i; boot pin is asynchronous.
*/
// Design decision made here: the Wishbone slave port.
`include "flash_status_consts.svh"

module flash_status_regs
#(
   parameter logic [15:0] MAKER_CODE   = `MAKER_CODE_DEFAULT,  // Arbitrary value
   parameter logic [15:0] PART_LAST4   = `PART_LAST4_DEFAULT,  // Arbitrary value
   parameter logic [19:0] PART_FULL    = `PART_FULL_DEFAULT,   // Arbitrary value
   parameter logic [31:0] PAGE_COUNT   = `PAGE_COUNT_DEFAULT,
   parameter logic [31:0] PAGE_SIZE    = `PAGE_SIZE_RESET,
   parameter logic        TWO_PER_BIT  = 1'b0
)
(
   // Clock, reset, enable
   input  wire logic                      clk_i,
   input  wire logic                      rst_i,
   input  wire logic                      ce_i,
   // Wishbone slave
   input  wire flash_status_pkg::wb_req_type wb_req_i,
   output flash_status_pkg::wb_rsp_type   wb_rsp_o,
   // Operation events
   input  wire flash_status_pkg::op_event_type ev_i,
   // Option bytes and identity sources
   input  wire logic [127:0]              option_page_protect_bits_i,
   input  wire logic [1:0]                option_security_bits_i,
   input  wire logic [127:0]              custom_identity_word_i,
   input  wire logic                      boot_pin_i,
   // Page guard request
   input  wire logic [7:0]                guard_page_i,
   input  wire logic                      guard_req_i,
   output logic                           guard_allow_o,
   output logic                           guard_refuse_o,
   // Status outputs
   output logic                           vector_source_select_o,
   output logic                           irq_o
);

   // ==========================================================
   // Register state
   logic [`FLAG_WIDTH-1:0] flags_reg;
   logic [`FLAG_WIDTH-1:0] flags_next;
   logic [`FLAG_WIDTH-1:0] irq_enable_reg;
   logic [127:0]           page_protect_reg;
   logic [1:0]             security_reg;
   logic                   vector_reg;
   logic                   reset_seen_reg;
   logic                   boot_meta_reg;
   logic                   boot_sync_reg;
   logic                   ack_reg;
   logic [31:0]            rdata_reg;
   logic                   irq_reg;
   flash_status_pkg::bus_state_type state_reg;

   // Word select for the multi-word registers
   function automatic logic [31:0] word_of(input logic [127:0] v, input logic [1:0] i);
      word_of = v[{i, 5'h00} +: 32];
   endfunction

   // ==========================================================
   // Bus decode
   wire logic        access;
   wire logic        wr_take;
   wire logic [11:0] adr;
   wire logic [31:0] wdat;
   wire logic        wr_flags;
   wire logic        wr_enable;
   wire logic        wr_vector;
   wire logic [31:0] rd_mux;

   assign access    = wb_req_i.cyc & wb_req_i.stb & (state_reg == flash_status_pkg::BUS_IDLE);
   assign wr_take   = access & wb_req_i.we & wb_req_i.sel[0];
   assign adr       = wb_req_i.adr;
   assign wdat      = wb_req_i.dat;
   assign wr_flags  = wr_take & (adr == `OFS_IRQ_STATUS);
   assign wr_enable = wr_take & (adr == `OFS_IRQ_ENABLE);
   assign wr_vector = wr_take & (adr == `OFS_VECTOR_MAP);

   // Read mux; unmapped and reserved bits read as zero
   assign rd_mux =
      (adr == `OFS_IRQ_ENABLE)  ? {29'h0000000, irq_enable_reg} :
      (adr == `OFS_IRQ_STATUS)  ? {29'h0000000, flags_reg} :
      (adr == `OFS_PAGE_PROT_0) ? word_of(page_protect_reg, 2'h0) :
      (adr == `OFS_PAGE_PROT_1) ? word_of(page_protect_reg, 2'h1) :
      (adr == `OFS_PAGE_PROT_2) ? word_of(page_protect_reg, 2'h2) :
      (adr == `OFS_PAGE_PROT_3) ? word_of(page_protect_reg, 2'h3) :
      (adr == `OFS_SECURITY)    ? {30'h0, security_reg} :
      (adr == `OFS_VECTOR_MAP)  ? {29'h0, vector_reg, 1'b0} :
      (adr == `OFS_MAKER_PART)  ? {MAKER_CODE, PART_LAST4} :
      (adr == `OFS_PAGE_COUNT)  ? PAGE_COUNT :
      (adr == `OFS_PAGE_SIZE)   ? PAGE_SIZE :
      (adr == `OFS_PART_ID)     ? {12'h000, PART_FULL} :
      (adr == `OFS_CUSTOM_0)    ? word_of(custom_identity_word_i, 2'h0) :
      (adr == `OFS_CUSTOM_1)    ? word_of(custom_identity_word_i, 2'h1) :
      (adr == `OFS_CUSTOM_2)    ? word_of(custom_identity_word_i, 2'h2) :
      (adr == `OFS_CUSTOM_3)    ? word_of(custom_identity_word_i, 2'h3) :
      `ZERO_WORD;

   // ==========================================================
   // Flag events and clears; a set in the clear cycle wins
   wire logic [`FLAG_WIDTH-1:0] set_vec;
   wire logic [`FLAG_WIDTH-1:0] clr_vec;
   wire logic                   bad_addr;
   wire logic                   checksum_cause;

   assign bad_addr       = ev_i.addr_check & (ev_i.target_address_value > `ADDR_LIMIT);
   assign checksum_cause = ev_i.checksum_bad & irq_enable_reg[`BIT_CHECKSUM];

   assign set_vec[`BIT_DONE]     = ev_i.op_done;
   assign set_vec[`BIT_BAD_ADDR] = bad_addr;
   assign set_vec[`BIT_CHECKSUM] = ev_i.checksum_bad;

   // Zero bits of the write leave flags alone
   assign clr_vec[`BIT_DONE]     = wr_flags & wdat[`BIT_DONE];
   assign clr_vec[`BIT_BAD_ADDR] = wr_flags & wdat[`BIT_BAD_ADDR];
   // Checksum flag ignores the clear while the cause persists
   assign clr_vec[`BIT_CHECKSUM] = wr_flags & wdat[`BIT_CHECKSUM] & ~checksum_cause;

   assign flags_next = (flags_reg & ~clr_vec) | set_vec;

   // ==========================================================
   // Boot pin synchroniser; second stage alone is read
   always_ff @(posedge clk_i)
   begin
      if (ce_i)
      begin
         boot_meta_reg <= boot_pin_i;
         boot_sync_reg <= boot_meta_reg;
      end
   end

   // Reset capture: option images load on the first enabled edge after
   // release, so straps are sampled by a clock, never by the reset itself
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         reset_seen_reg <= 1'b0;
      end
      else if (ce_i)
      begin
         reset_seen_reg <= 1'b1;
      end
   end

   // Protection images; frozen after load, later option changes unseen
   always_ff @(posedge clk_i)
   begin
      if (ce_i && !rst_i && !reset_seen_reg)
      begin
         page_protect_reg <= option_page_protect_bits_i;
         security_reg     <= option_security_bits_i;
      end
   end

   // Vector bit: boot pin at reset, software may rewrite afterwards
   always_ff @(posedge clk_i)
   begin
      if (ce_i)
      begin
         if (rst_i || !reset_seen_reg)
            vector_reg <= boot_sync_reg;
         else if (wr_vector)
            vector_reg <= wdat[`BIT_VECTOR_SEL];
      end
   end

   // ==========================================================
   // Flags and interrupt enables
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         flags_reg      <= '0;
         irq_enable_reg <= '0;
      end
      else if (ce_i)
      begin
         flags_reg <= flags_next;
         if (wr_enable)
            irq_enable_reg <= wdat[`FLAG_WIDTH-1:0];
      end
   end

   // Level interrupt from enabled flags
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
         irq_reg <= 1'b0;
      else if (ce_i)
         irq_reg <= |(flags_reg & irq_enable_reg);
   end

   // ==========================================================
   // Bus slave: ack one cycle after the request, then one idle cycle
   // so ack drops before a held request could be taken twice
   always_ff @(posedge clk_i)
   begin
      if (rst_i)
      begin
         state_reg <= flash_status_pkg::BUS_IDLE;
         ack_reg   <= 1'b0;
         rdata_reg <= `ZERO_WORD;
      end
      else if (ce_i)
      begin
         case (state_reg)
            flash_status_pkg::BUS_IDLE:
            begin
               if (access)
               begin
                  state_reg <= flash_status_pkg::BUS_ACK;
                  ack_reg   <= 1'b1;
                  rdata_reg <= wb_req_i.we ? `ZERO_WORD : rd_mux;
               end
            end
            flash_status_pkg::BUS_ACK:
            begin
               state_reg <= flash_status_pkg::BUS_IDLE;
               ack_reg   <= 1'b0;
            end
            default:
            begin
               state_reg <= flash_status_pkg::BUS_IDLE;
               ack_reg   <= 1'b0;
            end
         endcase
      end
   end

   assign wb_rsp_o.ack = ack_reg;
   assign wb_rsp_o.dat = rdata_reg;
   assign irq_o        = irq_reg;
   assign vector_source_select_o = vector_reg;

   // ==========================================================
   // Page guard on the latched protection image
   flash_page_guard u_guard
   (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .ce_i        (ce_i),
      .two_pages_i (TWO_PER_BIT),
      .page_i      (guard_page_i),
      .req_i       (guard_req_i),
      .protect_i   (page_protect_reg),
      .allow_o     (guard_allow_o),
      .refuse_o    (guard_refuse_o)
   );

endmodule

//--- flash_status_sva.sv
/*
 Checker for the flash status bank: bus answer, interrupt, guard and vector.
 Assumes a bind to flash_status_regs with ce_i held high.
*/
module flash_status_sva
(
   // Watched ports
   input wire logic                            clk_i,
   input wire logic                            rst_i,
   input wire logic                            ce_i,
   input wire flash_status_pkg::wb_req_type    wb_req_i,
   input wire flash_status_pkg::wb_rsp_type    wb_rsp_o,
   input wire flash_status_pkg::op_event_type  ev_i,
   input wire logic [127:0]                    option_page_protect_bits_i,
   input wire logic                            boot_pin_i,
   input wire logic [7:0]                      guard_page_i,
   input wire logic                            guard_req_i,
   input wire logic                            guard_allow_o,
   input wire logic                            guard_refuse_o,
   input wire logic                            vector_source_select_o,
   input wire logic                            irq_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Shadow of the enable register and the latched protection image
   logic [2:0]   en_reg;
   logic         ld_reg;
   logic [127:0] img_reg;
   wire          en_wr = ce_i && wb_req_i.cyc && wb_req_i.stb && wb_req_i.we
                         && wb_req_i.sel[0] && !wb_rsp_o.ack && wb_req_i.adr == 12'h014;
   wire          refuse_exp = guard_page_i[7] || !img_reg[guard_page_i[6:0]];

   // Image copies at every edge after a reset edge, last at the first edge after reset, like the bank
   always_ff @(posedge clk_i)
   begin
      ld_reg <= rst_i;
      if (rst_i)
         en_reg <= 3'h0;
      else if (en_wr)
         en_reg <= wb_req_i.dat[2:0];
      if (ld_reg)
         img_reg <= option_page_protect_bits_i;
   end

   // ==========================================================
   // Properties
   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);
   sequence s_req_rise;
      ce_i && $rose(wb_req_i.cyc && wb_req_i.stb);
   endsequence

   a_ack_one_cycle: assert property (wb_rsp_o.ack |=> !wb_rsp_o.ack)
      else $error("ack held longer than one cycle");
   a_ack_after_req: assert property (s_req_rise |=> wb_rsp_o.ack)
      else $error("no ack one cycle after request");
   a_irq_all_masked: assert property ((en_reg == 3'h0) |=> !irq_o)
      else $error("interrupt with all enables clear");
   a_done_irq: assert property ((ev_i.op_done && en_reg[0]) ##1 en_reg[0] |=> irq_o)
      else $error("no interrupt after operation done");
   a_bad_addr_irq: assert property ((ev_i.addr_check && ev_i.target_address_value > 32'h1fff_ffff
      && en_reg[1]) ##1 en_reg[1] |=> irq_o)
      else $error("no interrupt after bad address");
   a_sum_err_irq: assert property ((ev_i.checksum_bad && en_reg[2]) [*2] |=> irq_o)
      else $error("no interrupt on checksum error");
   a_vector_boot: assert property ($fell(rst_i) && boot_pin_i == $past(boot_pin_i, 3)
      |=> vector_source_select_o == $past(boot_pin_i))
      else $error("vector bit differs from boot pin");
   a_guard_answer: assert property (guard_req_i && !ld_reg
      |=> guard_refuse_o == $past(refuse_exp) && guard_allow_o != guard_refuse_o)
      else $error("guard answer wrong");
   a_guard_quiet: assert property (!guard_req_i |=> !guard_allow_o && !guard_refuse_o)
      else $error("guard answer without request");
endmodule

//--- flash_status_regs_bench.sv
/*
 Self-checking bench of the flash status and identity register bank.
 Assumes the package and constants header compile first.
*/
module flash_status_regs_bench;
   timeunit 1ns;
   timeprecision 1ps;

   // ==========================================================
   // Stimulus values; identity words are arbitrary
   localparam logic [127:0] OPT = {32'h0123_4567, 32'h89ab_cdef, 32'hfedc_ba98, 32'h7654_3210};
   localparam logic [127:0] CID = {32'hc3c3_0003, 32'hc2c2_0002, 32'hc1c1_0001, 32'hc0c0_0000};
   localparam logic [15:0]  MK  = 16'h0c0d;
   localparam logic [15:0]  PL  = 16'h1357;
   localparam logic [19:0]  PF  = 20'h21357;
   localparam logic [11:0]  ADR [14] = '{12'h020, 12'h024, 12'h028, 12'h02c, 12'h030, 12'h180,
      12'h184, 12'h188, 12'h18c, 12'h310, 12'h314, 12'h318, 12'h31c, 12'h200};
   logic                           clk = 1'b0;
   logic                           rst = 1'b1;
   logic                           boot = 1'b1;
   logic [127:0]                   opt = OPT;
   logic [7:0]                     gpage = 8'h00;
   logic                           greq = 1'b0;
   flash_status_pkg::wb_req_type   req = '0;
   flash_status_pkg::op_event_type ev = '0;
   flash_status_pkg::wb_rsp_type   rsp;
   logic                           gallow;
   logic                           grefuse;
   logic                           vsel;
   logic                           irq;
   int                             n_mismatch = 0;
   int                             total_checks = 0;

   always #2.5 clk = ~clk;

   flash_status_regs #(.MAKER_CODE(MK), .PART_LAST4(PL), .PART_FULL(PF),
      .PAGE_COUNT(32'h0000_0040), .PAGE_SIZE(32'h0000_0400), .TWO_PER_BIT(1'b0))
   flash_status_regs_i
   (
      .clk_i(clk), .rst_i(rst), .ce_i(1'b1), .wb_req_i(req), .wb_rsp_o(rsp), .ev_i(ev),
      .option_page_protect_bits_i(opt), .option_security_bits_i(2'b10),
      .custom_identity_word_i(CID), .boot_pin_i(boot), .guard_page_i(gpage),
      .guard_req_i(greq), .guard_allow_o(gallow), .guard_refuse_o(grefuse),
      .vector_source_select_o(vsel), .irq_o(irq)
   );

   // ==========================================================
   // Shared tasks
   task automatic finish_test;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("mismatch at %0t got %h expected %h", $time, g, e);
      end
   endtask

   // Bounded wait for ack so a dead slave cannot hang the run
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      int n;
      n = 0;
      req <= '{1'b1, 1'b1, w, 4'hf, a, d};
      do
      begin
         @(posedge clk);
         n++;
      end
      while (rsp.ack !== 1'b1 && n < 20);
      q = rsp.dat;
      req <= '0;
      if (rsp.ack !== 1'b1)
      begin
         n_mismatch++;
         finish_test;
      end
      @(posedge clk);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      chk(q, e);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask

   task automatic do_reset;
      rst <= 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
   endtask

   task automatic pulse(input logic [1:0] m, input logic [31:0] t);
      ev.op_done <= m[0];
      ev.addr_check <= m[1];
      ev.target_address_value <= t;
      @(posedge clk);
      ev.op_done <= 1'b0;
      ev.addr_check <= 1'b0;
      @(posedge clk);
   endtask

   task automatic guard(input logic [7:0] p, input logic a);
      gpage <= p;
      greq <= 1'b1;
      @(posedge clk);
      greq <= 1'b0;
      @(posedge clk);
      chk({30'h0, gallow, grefuse}, {30'h0, a, !a});
   endtask

   // ==========================================================
   // Scenarios
   // Read-only words keep their value after a write of all ones
   task automatic t_ident;
      logic [31:0] e [14];
      e = '{OPT[31:0], OPT[63:32], OPT[95:64], OPT[127:96], 32'h2, {MK, PL}, 32'h40,
            32'h400, {12'h0, PF}, CID[31:0], CID[63:32], CID[95:64], CID[127:96], 32'h0};
      for (int i = 0; i < 14; i++)
      begin
         rd(ADR[i], e[i]); // Value
         wr(ADR[i], 32'hffff_ffff);
         rd(ADR[i], e[i]); // After write
      end
   endtask

   task automatic t_vector;
      rd(12'h100, 32'h2);
      chk({31'h0, vsel}, 32'h1);
      wr(12'h100, 32'h0);
      rd(12'h100, 32'h0);
      chk({31'h0, vsel}, 32'h0);
   endtask

   task automatic t_flags;
      wr(12'h014, 32'h7);
      pulse(2'b01, 32'h0);
      rd(12'h018, 32'h1);
      chk({31'h0, irq}, 32'h1);
      wr(12'h018, 32'h0);
      rd(12'h018, 32'h1);
      wr(12'h018, 32'h1);
      rd(12'h018, 32'h0);
      chk({31'h0, irq}, 32'h0);
      pulse(2'b10, 32'h1fff_ffff);
      rd(12'h018, 32'h0); // Upper limit is valid
      pulse(2'b10, 32'h2000_0000);
      rd(12'h018, 32'h2);
      wr(12'h018, 32'h2);
      rd(12'h018, 32'h0);
      ev.checksum_bad <= 1'b1;
      @(posedge clk);
      rd(12'h018, 32'h4);
      wr(12'h018, 32'h4);
      rd(12'h018, 32'h4); // Cause still present
      chk({31'h0, irq}, 32'h1);
      ev.checksum_bad <= 1'b0;
      wr(12'h018, 32'h4);
      rd(12'h018, 32'h0);
      wr(12'h014, 32'h0);
      pulse(2'b01, 32'h0);
      rd(12'h018, 32'h1);
      chk({31'h0, irq}, 32'h0); // Masked
      wr(12'h018, 32'h1);
   endtask

   // Image must not follow option changes until the next reset
   task automatic t_protect;
      opt <= ~OPT;
      rd(12'h020, OPT[31:0]);
      guard(8'd0, 1'b0);
      guard(8'd4, 1'b1);
      guard(8'd127, 1'b0);
      guard(8'd128, 1'b0);
      boot <= 1'b0;
      do_reset;
      rd(12'h020, ~OPT[31:0]);
      rd(12'h100, 32'h0);
      guard(8'd0, 1'b1);
   endtask

   initial
   begin
      do_reset;
      t_ident;
      t_vector;
      t_flags;
      t_protect;
      finish_test;
   end
endmodule

bind flash_status_regs flash_status_sva flash_status_sva_i
(
   .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
   .ev_i(ev_i), .option_page_protect_bits_i(option_page_protect_bits_i),
   .boot_pin_i(boot_pin_i), .guard_page_i(guard_page_i), .guard_req_i(guard_req_i),
   .guard_allow_o(guard_allow_o), .guard_refuse_o(guard_refuse_o),
   .vector_source_select_o(vector_source_select_o), .irq_o(irq_o)
);
